// >>> bench/ext_memory_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// external memory with programmable wait
module ext_memory_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] wait_cycles,
    input wire logic access_strobe_n,
    input wire logic read_not_write,
    input wire logic [23:0] addr_out,
    input wire logic [31:0] data_out,
    input wire logic data_oe_n,
    output logic ready_n,
    output logic [31:0] data_in
);
    logic [31:0] mem_q [16];
    logic [7:0] cnt_q;
    // ready only after the programmed wait, so slow devices are exercised
    assign ready_n = !(access_strobe_n == 1'b0 && cnt_q >= wait_cycles);
    // nobody driving: the device keeper holds the lines at its level
    assign data_in = !data_oe_n ? data_out
        : (!access_strobe_n && read_not_write) ? mem_q[addr_out[3:0]] : data_out;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            for (int i = 0; i < 16; i++) mem_q[i] <= 32'hC3000000 + i;
        end else begin
            cnt_q <= access_strobe_n ? 8'h00 : cnt_q + 8'h01;
            if (!access_strobe_n && !read_not_write && !ready_n) mem_q[addr_out[3:0]] <= data_out;
        end
    end
endmodule // ext_memory_model
`default_nettype wire

// >>> bench/primary_bus_hold_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module primary_bus_hold_port_tb;
    import primary_bus_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, marker = 1'b0, ovr = 1'b0;
    logic shz_n = 1'b1, hold_n = 1'b1, edge_sel = 1'b0;
    bus_req_t req = '0;
    logic [IRQ_N-1:0] irq_clr = '0, irq_n = 4'hF, pend;
    logic [7:0] wait_cycles = 8'h00;
    logic ready_n, req_ready, rsp_done, run_en, exec_start, strobe_n, strobe_oe_n, rw, rw_oe_n;
    logic addr_oe_n, data_oe_n, bank_oe_n, ack_n, ack_oe_n, mark_n, mark_oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_in, data_out, rdata, start_addr, rd;
    logic [BANK_N-1:0] bank_n;
    int failures = 0, comparisons = 0, cycles = 0;
    always #12.5 clk = ~clk;
    primary_bus_hold_port uut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_done(rsp_done), .rsp_rdata(rdata), .run_enable(run_en),
        .exec_start(exec_start), .start_addr(start_addr), .marker_instr(marker),
        .irq_clear(irq_clr), .irq_pending(pend), .release_override_bit(ovr),
        .pin_float_shutdown_n(shz_n), .bus_release_req_n(hold_n), .ready_n(ready_n),
        .addr_out(addr), .addr_oe_n(addr_oe_n), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .read_not_write(rw), .rw_oe_n(rw_oe_n),
        .access_strobe_n(strobe_n), .strobe_oe_n(strobe_oe_n), .bank_select_strobes_n(bank_n),
        .bank_oe_n(bank_oe_n), .bus_release_ack_n(ack_n), .ack_oe_n(ack_oe_n),
        .code_marker_pulse_n(mark_n), .marker_oe_n(mark_oe_n),
        .interrupt_edge_select(edge_sel), .external_irq_inputs_n(irq_n));
    ext_memory_model mem (.clk(clk), .rst_n(rst_n), .wait_cycles(wait_cycles),
        .access_strobe_n(strobe_n), .read_not_write(rw), .addr_out(addr),
        .data_out(data_out), .data_oe_n(data_oe_n), .ready_n(ready_n), .data_in(data_in));
    // ========================================
    // reporting
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_for(ref logic s, input logic v, input string what);
        for (int i = 0; i < 8 && s !== v; i++) tick(1);
        chk(what, v, s);
    endtask
    // ========================================
    // one core access, pins judged while the strobe is low
    task automatic access(input logic wr, input logic [23:0] a, input logic [31:0] wd);
        int n;
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{write: wr, addr: a, wdata: wd};
        do @(negedge clk); while (req_ready !== 1'b1);
        @(posedge clk);
        req_valid <= 1'b0;
        for (n = 1; n < 40; n++) begin
            #1;
            if (strobe_n === 1'b0) begin
                seen = 1'b1;
                chk("direction", !wr, rw);
                chk("data drive", !wr, data_oe_n);
                chk("bank", 4'(~(4'h1 << a[23:22])), bank_n);
                chk("address", a, addr);
                chk("ack in access", 1'b1, ack_n);
            end
            if (rsp_done === 1'b1) break;
            @(posedge clk);
        end
        chk("strobe seen", 1'b1, seen);
        chk("waited for ready", 1'b1, n > wait_cycles + 1);
        rd = rdata;
    endtask
    // ========================================
    // scenarios
    task automatic t_reset();
        tick(8);
        chk("strobe in reset", 2'b01, {strobe_oe_n, strobe_n});
        chk("floated in reset", 3'h7, {addr_oe_n, rw_oe_n, bank_oe_n});
        chk("run in reset", 1'b0, run_en);
        chk("ack in reset", 1'b1, ack_n);
        rst_n <= 1'b1;
        wait_for(exec_start, 1'b1, "vector done");
        chk("start address", 32'hC3000000, start_addr);
        tick(1);
        chk("running", 1'b1, run_en);
    endtask
    task automatic t_banks();
        logic [23:0] a;
        wait_cycles <= 8'h03;
        for (int b = 0; b < 4; b++) begin
            a = {2'(b), 18'h0, 4'(b + 1)};
            access(1'b1, a, 32'h5A000000 + b);
            tick(2);
            chk("keeper", 32'h5A000000 + b, data_out);
            access(1'b0, a, 32'h00000000);
            chk("read data", 32'h5A000000 + b, rd);
            chk("keeper after read", 32'h5A000000 + b, data_out);
        end
    endtask
    task automatic t_release();
        fork
            access(1'b1, 24'h000009, 32'h12345678);
            begin
                repeat (3) @(posedge clk);
                hold_n <= 1'b0;
            end
        join
        wait_for(ack_n, 1'b0, "release ack");
        chk("floated", 5'h1F, {addr_oe_n, data_oe_n, rw_oe_n, strobe_oe_n, bank_oe_n});
        @(posedge clk);
        req_valid <= 1'b1;
        tick(4);
        chk("no new access", 1'b0, req_ready);
        req_valid <= 1'b0;
        hold_n <= 1'b1;
        wait_for(ack_n, 1'b1, "ack on request high");
        chk("driven again", 1'b0, addr_oe_n);
        hold_n <= 1'b0;
        wait_for(ack_n, 1'b0, "second release");
        ovr <= 1'b1;
        wait_for(ack_n, 1'b1, "ack on override");
        access(1'b0, 24'h000009, 32'h00000000);
        chk("resumed read", 32'h12345678, rd);
        hold_n <= 1'b1;
        ovr <= 1'b0;
    endtask
    task automatic t_irq_marker();
        int lows;
        lows = 0;
        edge_sel <= 1'b1;
        irq_n <= 4'hE;
        tick(3);
        chk("edge pending", 4'h1, pend);
        irq_clr <= 4'h1;
        tick(1);
        irq_clr <= 4'h0;
        tick(2);
        // pin still low: edge mode must not set it again
        chk("edge cleared", 4'h0, pend);
        edge_sel <= 1'b0;
        irq_n <= 4'hB;
        tick(3);
        chk("level pending", 4'h4, pend);
        irq_n <= 4'hF;
        marker <= 1'b1;
        tick(1);
        marker <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            lows += (mark_n === 1'b0);
            tick(1);
        end
        chk("marker pulses", 1, lows);
    endtask
    initial begin
        t_reset();
        t_banks();
        t_release();
        t_irq_marker();
        // shutdown last: it floats every driven pin
        shz_n <= 1'b0;
        tick(1);
        chk("shutdown float", 7'h7F, {addr_oe_n, data_oe_n, rw_oe_n, strobe_oe_n,
            bank_oe_n, ack_oe_n, mark_oe_n});
        end_of_test();
    end
endmodule // primary_bus_hold_port_tb
`default_nettype wire

// >>> shared/primary_bus_pkg.sv
// Behaviour
// (RULE1) direction high on reads, low on writes
// (RULE2) release request waits for running access
// (RULE3) released bus floats and starts nothing
// (RULE4) resume on request high or override
// (RULE5) acknowledge low only once bus floated
// (RULE6) acknowledge high on request high or override
// (RULE7) outside device signals ready; access waits
// (RULE8) one bank strobe decoded per access
// (RULE9) access strobe asserted on every access
// (RULE10) no execution while reset is low
// (RULE11) after reset fetch vector, start there
// (RULE12) edge select makes interrupts edge detected
// (RULE13) marker pulse per acknowledge instruction
// (RULE14) data lines keep their last level
// (RULE15) address, direction, banks float in reset/release
// (RULE16) access strobe driven in reset, floats otherwise; the code floats it only in release or shutdown
// (RULE17) release request and ready sampled on clock
`default_nettype none
package primary_bus_pkg;
    // ========================================
    // widths and fields
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int IRQ_N = 4;
    localparam int BANK_N = 4;
    localparam int BANK_LSB = 22;
    localparam int BANK_W = 2;
    // ========================================
    // reset values
    localparam logic [ADDR_W-1:0] VECTOR_ADDR = 24'h000000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
    localparam logic [BANK_N-1:0] BANK_IDLE = 4'hF;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_RELEASED
    } bus_state_t;
endpackage
`default_nettype wire

// >>> verilog/primary_bus_hold_port.sv
`timescale 1ns/1ps
`default_nettype none
module primary_bus_hold_port (
    input wire logic clk,
    input wire logic rst_n,
    // core side
    input wire logic req_valid,
    input wire primary_bus_pkg::bus_req_t req,
    output logic req_ready,
    output logic rsp_done,
    output logic [primary_bus_pkg::DATA_W-1:0] rsp_rdata,
    output logic run_enable,
    output logic exec_start,
    output logic [primary_bus_pkg::DATA_W-1:0] start_addr,
    input wire logic marker_instr,
    input wire logic [primary_bus_pkg::IRQ_N-1:0] irq_clear,
    output logic [primary_bus_pkg::IRQ_N-1:0] irq_pending,
    input wire logic release_override_bit,
    // pins
    input wire logic pin_float_shutdown_n,
    input wire logic bus_release_req_n,
    input wire logic ready_n,
    output logic [primary_bus_pkg::ADDR_W-1:0] addr_out,
    output logic addr_oe_n,
    input wire logic [primary_bus_pkg::DATA_W-1:0] data_in,
    output logic [primary_bus_pkg::DATA_W-1:0] data_out,
    output logic data_oe_n,
    output logic read_not_write,
    output logic rw_oe_n,
    output logic access_strobe_n,
    output logic strobe_oe_n,
    output logic [primary_bus_pkg::BANK_N-1:0] bank_select_strobes_n,
    output logic bank_oe_n,
    output logic bus_release_ack_n,
    output logic ack_oe_n,
    output logic code_marker_pulse_n,
    output logic marker_oe_n,
    input wire logic interrupt_edge_select,
    input wire logic [primary_bus_pkg::IRQ_N-1:0] external_irq_inputs_n
);
    import primary_bus_pkg::*;

    function automatic logic [BANK_N-1:0] bank_decode(input logic [ADDR_W-1:0] a);
        bank_decode = ~(BANK_N'(1) << a[BANK_LSB +: BANK_W]);
    endfunction

    // ========================================
    // input sampling
    logic hold_s_q, rdy_s_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_s_q <= 1'b0;
            rdy_s_q <= 1'b0;
        end else begin
            hold_s_q <= ~bus_release_req_n; // RULE17
            rdy_s_q <= ~ready_n; // RULE17
        end
    end

    // ========================================
    // bus sequencer
    bus_state_t state_q, state_d;
    logic vec_pend_q, first_q, cur_write_q, run_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] keep_q, rdata_q, start_q;
    logic [BANK_N-1:0] bank_q;
    logic strobe_q, done_q, start_pulse_q;
    logic addr_oe_n_q, data_oe_n_q;

    wire release_req = hold_s_q & ~release_override_bit;
    wire access_end = (state_q == ST_ACCESS) & ~first_q & rdy_s_q; // RULE7
    wire go_idle = (state_q == ST_IDLE) & ~release_req;
    wire take_vec = go_idle & vec_pend_q; // RULE11
    wire take_core = go_idle & ~vec_pend_q & req_valid;
    wire [ADDR_W-1:0] next_addr = take_vec ? VECTOR_ADDR : req.addr;
    wire next_write = take_core & req.write;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (release_req) begin
                    state_d = ST_RELEASED; // RULE2
                end else if (take_vec | take_core) begin
                    state_d = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                // a release request waits here until the access ends
                if (access_end) begin
                    state_d = ST_IDLE; // RULE2
                end
            end
            ST_RELEASED: begin
                if (!release_req) begin
                    state_d = ST_IDLE; // RULE4
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            first_q <= 1'b0;
            cur_write_q <= 1'b0;
            addr_q <= ADDR_RST;
            bank_q <= BANK_IDLE;
            strobe_q <= 1'b0;
            addr_oe_n_q <= 1'b1;
            data_oe_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            first_q <= take_vec | take_core;
            addr_oe_n_q <= (state_d == ST_RELEASED); // RULE3 RULE15
            if (take_vec | take_core) begin
                cur_write_q <= next_write;
                addr_q <= next_addr;
                bank_q <= bank_decode(next_addr); // RULE8
                strobe_q <= 1'b1; // RULE9
                data_oe_n_q <= ~next_write;
            end else if (access_end) begin
                bank_q <= BANK_IDLE;
                strobe_q <= 1'b0;
                data_oe_n_q <= 1'b1;
            end
        end
    end

    // ========================================
    // data keeper, vector and results
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            keep_q <= DATA_RST;
            rdata_q <= DATA_RST;
            start_q <= DATA_RST;
            vec_pend_q <= 1'b1;
            run_q <= 1'b0;
            done_q <= 1'b0;
            start_pulse_q <= 1'b0;
        end else begin
            // keeper follows whoever drove last, so a floated line holds
            if (take_core & req.write) begin
                keep_q <= req.wdata; // RULE14
            end else if (data_oe_n_q) begin
                keep_q <= data_in; // RULE14
            end
            done_q <= access_end & ~vec_pend_q;
            start_pulse_q <= access_end & vec_pend_q;
            if (access_end & ~cur_write_q) begin
                rdata_q <= data_in;
            end
            if (access_end & vec_pend_q) begin
                start_q <= data_in; // RULE11
                vec_pend_q <= 1'b0;
                run_q <= 1'b1; // RULE10
            end
        end
    end

    // ========================================
    // interrupt inputs and code marker
    logic [IRQ_N-1:0] irq_s_q, irq_prev_q, irq_pend_q;
    logic marker_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_s_q <= '0;
            irq_prev_q <= '0;
            marker_q <= 1'b0;
        end else begin
            irq_s_q <= ~external_irq_inputs_n;
            irq_prev_q <= irq_s_q;
            marker_q <= marker_instr & run_q; // RULE13
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < IRQ_N; gi++) begin : g_irq
            wire fell = irq_s_q[gi] & ~irq_prev_q[gi];
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    irq_pend_q[gi] <= 1'b0;
                end else if (interrupt_edge_select) begin
                    // set wins over a clear in the same cycle
                    irq_pend_q[gi] <= fell | (irq_pend_q[gi] & ~irq_clear[gi]); // RULE12
                end else begin
                    irq_pend_q[gi] <= irq_s_q[gi]; // RULE12
                end
            end
        end
    endgenerate

    // ========================================
    // pin drive
    wire pin_float_shutdown = ~pin_float_shutdown_n;
    wire released = (state_q == ST_RELEASED);
    assign addr_out = addr_q;
    assign addr_oe_n = addr_oe_n_q | pin_float_shutdown; // RULE3 RULE15
    assign rw_oe_n = addr_oe_n_q | pin_float_shutdown; // RULE15
    assign bank_oe_n = addr_oe_n_q | pin_float_shutdown; // RULE15
    assign read_not_write = ~cur_write_q; // RULE1
    assign data_out = keep_q;
    assign data_oe_n = data_oe_n_q | released | pin_float_shutdown; // RULE3
    assign access_strobe_n = ~strobe_q;
    // only shutdown or release floats the strobe; reset keeps it high
    assign strobe_oe_n = released | pin_float_shutdown; // RULE16
    assign bank_select_strobes_n = bank_q;
    assign bus_release_ack_n = ~released; // RULE5 RULE6
    assign ack_oe_n = pin_float_shutdown;
    assign code_marker_pulse_n = ~marker_q;
    assign marker_oe_n = pin_float_shutdown;
    assign req_ready = take_core;
    assign rsp_done = done_q;
    assign rsp_rdata = rdata_q;
    assign run_enable = run_q;
    assign exec_start = start_pulse_q;
    assign start_addr = start_q;
    assign irq_pending = irq_pend_q;

    // ========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_rw_dir;
        take_vec || take_core |=> read_not_write == !$past(next_write) && data_oe_n == !$past(next_write);
    endproperty
    a_rw_dir: assert property (p_rw_dir) else $error("direction wrong"); // RULE1

    property p_finish_first;
        (state_q == ST_ACCESS) && !access_end |=> state_q != ST_RELEASED;
    endproperty
    a_finish_first: assert property (p_finish_first) else $error("released mid access"); // RULE2

    property p_float_released;
        released |-> addr_oe_n && data_oe_n && strobe_oe_n && rw_oe_n && bank_oe_n && !strobe_q;
    endproperty
    a_float_released: assert property (p_float_released) else $error("bus driven in release"); // RULE3

    property p_resume;
        released && !release_req |=> !released;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume"); // RULE4

    property p_ack_low;
        !bus_release_ack_n |-> addr_oe_n && $past(hold_s_q);
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack before float"); // RULE5

    property p_ack_high;
        !hold_s_q || release_override_bit |=> bus_release_ack_n;
    endproperty
    a_ack_high: assert property (p_ack_high) else $error("ack not high"); // RULE6

    property p_wait_ready;
        strobe_q && !rdy_s_q |=> strobe_q;
    endproperty
    a_wait_ready: assert property (p_wait_ready) else $error("access ended early"); // RULE7

    property p_bank;
        strobe_q |-> $onehot(~bank_select_strobes_n) && !bank_select_strobes_n[addr_out[BANK_LSB +: BANK_W]];
    endproperty
    a_bank: assert property (p_bank) else $error("bank decode wrong"); // RULE8

    property p_strobe;
        take_vec || take_core |=> strobe_q [*2];
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe missing"); // RULE9

    property p_vector;
        access_end && vec_pend_q |=> exec_start && run_enable && start_addr == $past(data_in);
    endproperty
    a_vector: assert property (p_vector) else $error("vector not taken"); // RULE11

    property p_marker;
        marker_instr && run_q |=> !code_marker_pulse_n ##1 (code_marker_pulse_n || $past(marker_instr));
    endproperty
    a_marker: assert property (p_marker) else $error("marker missing"); // RULE13

    property p_edge;
        interrupt_edge_select && irq_s_q[0] && !irq_prev_q[0] |=> irq_pending[0];
    endproperty
    a_edge: assert property (p_edge) else $error("edge lost"); // RULE12

    c_read: cover property (take_core && !req.write ##[2:20] rsp_done);
    c_write: cover property (take_core && req.write ##[2:20] rsp_done);
    c_release: cover property (access_end && release_req ##2 released);
    c_override: cover property (released && release_override_bit ##1 !released);
endmodule // primary_bus_hold_port
`default_nettype wire
